// >>> pssq_regs.svh
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef PSSQ_REGS_SVH
`define PSSQ_REGS_SVH

`define PSSQ_ADDR_W        8
`define PSSQ_CTRL          8'h00
`define PSSQ_MAXF          8'h04
`define PSSQ_GACC1         8'h08
`define PSSQ_GDEC1         8'h0C
`define PSSQ_GACC2         8'h10
`define PSSQ_GDEC2         8'h14
`define PSSQ_PRESET_F      8'h20
`define PSSQ_PRESET_ACC    8'h40
`define PSSQ_PRESET_DEC    8'h60
`define PSSQ_SEQ_F         8'h80
`define PSSQ_SEQ_T         8'hA0
`define PSSQ_SEQ_DIR       8'hC0
`define PSSQ_STATUS        8'hE0
`define PSSQ_FREQ_OUT      8'hE4
`define PSSQ_RAMP_OUT      8'hE8
`define PSSQ_TABLE_SPAN    8'h20

`define PSSQ_CTRL_INDIV    0
`define PSSQ_CTRL_PAIR2    1
`define PSSQ_CTRL_VF_LO    2
`define PSSQ_CTRL_VF_HI    4
`define PSSQ_CTRL_BASE60   5
`define PSSQ_CTRL_MODE_LO  6
`define PSSQ_CTRL_MODE_HI  8
`define PSSQ_CTRL_TERM_LO  9
`define PSSQ_CTRL_TERM_HI  13

`define PSSQ_VF_PROGRAM    3'h7
`define PSSQ_FMAX_50       16'h1388
`define PSSQ_FMAX_60       16'h1770
`define PSSQ_FREQ_LIMIT    16'hFDE8
`define PSSQ_TIME_LIMIT    16'h8CA0
`define PSSQ_RAMP_MIN      16'h0001
`define PSSQ_MAXF_RST      16'h1770
`define PSSQ_RAMP_RST      16'h0064
`define PSSQ_DIR_STOP      2'h0
`define PSSQ_DIR_FWD       2'h1
`define PSSQ_DIR_REV       2'h2

`define PSSQ_CLK_HZ        20000000
`define PSSQ_TICK_MS       100
`define PSSQ_TICK_CYCLES   (`PSSQ_CLK_HZ / 1000 * `PSSQ_TICK_MS)

`endif

// >>> pssq_pkg.sv
// types of the preset speed sequencer
package pssq_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01,
    SEQ_HOLD = 2'b10,
    SEQ_DONE = 2'b11
  } pssq_seq_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  count;
    logic [16:0] rem;
    logic [31:0] quo;
    logic [15:0] divisor;
  } pssq_div_state_t;

  typedef struct packed {
    logic [9:0]        sync1;
    logic [9:0]        sync2;
    logic              rampIndiv;
    logic              pairSel;
    logic [2:0]        vfPattern;
    logic              base60;
    logic [2:0]        seqMode;
    logic [4:0]        termMask;
    logic [15:0]       maxFreq;
    logic [1:0][15:0]  gAcc;
    logic [1:0][15:0]  gDec;
    logic [7:0][15:0]  presetFreq;
    logic [7:0][15:0]  presetAcc;
    logic [7:0][15:0]  presetDec;
    logic [7:1][15:0]  seqFreq;
    logic [7:0][15:0]  seqTime;
    logic [7:0][1:0]   seqDir;
    pssq_seq_t         seqState;
    logic [2:0]        step;
    logic [15:0]       elapsed;
    logic [20:0]       tickCnt;
    logic              paused;
    logic [15:0]       lastTarget;
    logic [2:0]        lastIdx;
    logic              divStart;
    logic [31:0]       dividend;
    logic [15:0]       divisor;
    logic [15:0]       pendFreq;
    logic [15:0]       freqRef;
    logic [15:0]       rampTime;
    logic              rampStrobe;
    logic              forward_direction;
    logic              reverse_direction;
    logic              outRun;
    logic [31:0]       rdata;
  } pssq_state_t;

endpackage

// >>> pssq_div_if.sv
// ramp time divider request and answer
`timescale 1ns/100ps
interface pssq_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic        busy;
  logic        done;
  logic [31:0] quotient;

  modport req (output start, output dividend, output divisor,
               input busy, input done, input quotient);
  modport rsp (input start, input dividend, input divisor,
               output busy, output done, output quotient);
endinterface

// >>> pssq_div.sv
// serial divider for the ramp time scaling
`timescale 1ns/100ps
module pssq_div
  import pssq_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  pssq_div_if.rsp   div
);
  import pssq_pkg::*;

  pssq_div_state_t q;
  pssq_div_state_t d;
  logic [16:0]     remShift;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    remShift = {q.rem[15:0], q.quo[31]};
    if (!q.busy && div.start)
    begin
      d.busy = 1'b1;
      d.count = 6'h20;
      d.rem = 17'h00000;
      d.quo = div.dividend;
      d.divisor = div.divisor;
    end
    else if (q.busy)
    begin
      d.quo = {q.quo[30:0], 1'b0};
      if (remShift >= {1'b0, q.divisor})
      begin
        d.rem = remShift - {1'b0, q.divisor};
        d.quo[0] = 1'b1;
      end
      else
      begin
        d.rem = remShift;
      end
      d.count = q.count - 6'h01;
      if (q.count == 6'h01)
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign div.busy = q.busy;
  assign div.done = q.done;
  assign div.quotient = q.quo;
endmodule

// >>> pssq_top.sv
// preset speed selection, ramp time scaling and automatic step sequencer
// Operation
// - mode bit picks shared or per-preset ramps
// - eight preset speeds, preset 0 is keypad
// - per-preset acceleration and deceleration times held
// - shared mode uses selected global ramp pair
// - ramp time scaled by frequency over maximum
// - divisor is maximum frequency or 50/60
// - on/off run ramps zero to preset
// - continuous run ramps by frequency difference
// - sequencer mode decode single, periodic, hold
// - modes 1-3 resume unfinished step
// - modes 4-6 restart from the first step with nonzero duration
// - step 0 frequency is preset 0
// - step 1-7 frequency commands held
// - each step runs its own duration
// - per-step direction stop, forward, reverse
// - single cycle runs steps then stops
// - periodic cycle repeats from the first step with nonzero duration
// - sequencer ramps with global ramp pair
`timescale 1ns/100ps
`include "pssq_regs.svh"
module pssq_top
  import pssq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PSSQ_TICK_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic        runCommand,
  input  wire logic        reverseCommand,
  input  wire logic        multifunctionInput1,
  input  wire logic        multifunctionInput2,
  input  wire logic        multifunctionInput3,
  input  wire logic        multifunctionInput4,
  input  wire logic        multifunctionInput5,
  input  wire logic [2:0]  presetSelect,
  output logic      [15:0] freqReference,
  output logic      [15:0] rampTime,
  output logic             rampUpdate,
  output logic             forwardDirection,
  output logic             reverseDirection,
  output logic             outputRun
);
  import pssq_pkg::*;

  localparam logic [20:0] TICK_LAST = 21'(TICK_CYCLES - 1);

  pssq_state_t q;
  pssq_state_t d;
  pssq_div_if  divBus ();

  logic        runIn;
  logic        revIn;
  logic [4:0]  termIn;
  logic [2:0]  selIn;
  logic        seqEnable;
  logic        modeSingle;
  logic        modePeriodic;
  logic        modeHold;
  logic        modeFresh;
  logic        anyStep;
  logic [2:0]  firstStep;
  logic [2:0]  lastStep;
  logic [2:0]  nextStep;
  logic        tick;
  logic [15:0] target;
  logic [1:0]  dirCode;
  logic [15:0] rampBase;
  logic [15:0] fmax;
  logic [15:0] delta;
  logic [2:0]  rampIdx;
  logic [2:0]  idx;
  logic [15:0] stepFreq;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pins
  assign runIn  = q.sync2[0];
  assign revIn  = q.sync2[1];
  assign termIn = q.sync2[6:2];
  assign selIn  = q.sync2[9:7];

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    d = q;
    d.divStart = 1'b0;
    d.rampStrobe = 1'b0;
    d.rdata = 32'h00000000;
    d.sync1 = {presetSelect, multifunctionInput5, multifunctionInput4, multifunctionInput3,
               multifunctionInput2, multifunctionInput1, reverseCommand, runCommand};
    d.sync2 = q.sync1;
    idx = regAddr[4:2];

    // register writes
    if (regWrite)
    begin
      if (regAddr == `PSSQ_CTRL)
      begin
        d.rampIndiv = regWdata[`PSSQ_CTRL_INDIV];
        d.pairSel = regWdata[`PSSQ_CTRL_PAIR2];
        d.vfPattern = regWdata[`PSSQ_CTRL_VF_HI:`PSSQ_CTRL_VF_LO];
        d.base60 = regWdata[`PSSQ_CTRL_BASE60];
        d.seqMode = regWdata[`PSSQ_CTRL_MODE_HI:`PSSQ_CTRL_MODE_LO];
        d.termMask = regWdata[`PSSQ_CTRL_TERM_HI:`PSSQ_CTRL_TERM_LO];
      end
      else if (regAddr == `PSSQ_MAXF)
        d.maxFreq = regWdata[15:0];
      else if (regAddr == `PSSQ_GACC1)
        d.gAcc[0] = regWdata[15:0];
      else if (regAddr == `PSSQ_GDEC1)
        d.gDec[0] = regWdata[15:0];
      else if (regAddr == `PSSQ_GACC2)
        d.gAcc[1] = regWdata[15:0];
      else if (regAddr == `PSSQ_GDEC2)
        d.gDec[1] = regWdata[15:0];
      else if (regAddr >= `PSSQ_PRESET_F && regAddr < `PSSQ_PRESET_ACC)
      begin
        if (regWdata[15:0] <= `PSSQ_FREQ_LIMIT)
          d.presetFreq[idx] = regWdata[15:0];
      end
      else if (regAddr >= `PSSQ_PRESET_ACC && regAddr < `PSSQ_PRESET_DEC)
      begin
        if (regWdata[15:0] >= `PSSQ_RAMP_MIN && regWdata[15:0] <= `PSSQ_TIME_LIMIT)
          d.presetAcc[idx] = regWdata[15:0];
      end
      else if (regAddr >= `PSSQ_PRESET_DEC && regAddr < `PSSQ_SEQ_F)
      begin
        if (regWdata[15:0] >= `PSSQ_RAMP_MIN && regWdata[15:0] <= `PSSQ_TIME_LIMIT)
          d.presetDec[idx] = regWdata[15:0];
      end
      else if (regAddr >= `PSSQ_SEQ_F && regAddr < `PSSQ_SEQ_T)
      begin
        if (idx != 3'h0 && regWdata[15:0] <= `PSSQ_FREQ_LIMIT)
          d.seqFreq[idx] = regWdata[15:0];
      end
      else if (regAddr >= `PSSQ_SEQ_T && regAddr < `PSSQ_SEQ_DIR)
      begin
        if (regWdata[15:0] <= `PSSQ_TIME_LIMIT)
          d.seqTime[idx] = regWdata[15:0];
      end
      else if (regAddr >= `PSSQ_SEQ_DIR && regAddr < `PSSQ_STATUS)
        d.seqDir[idx] = regWdata[1:0];
    end

    // register reads, answer in the next cycle
    if (regRead)
    begin
      if (regAddr == `PSSQ_CTRL)
        d.rdata = {18'h00000, q.termMask, q.seqMode, q.base60, q.vfPattern, q.pairSel,
                   q.rampIndiv};
      else if (regAddr == `PSSQ_MAXF)
        d.rdata = {16'h0000, q.maxFreq};
      else if (regAddr == `PSSQ_GACC1)
        d.rdata = {16'h0000, q.gAcc[0]};
      else if (regAddr == `PSSQ_GDEC1)
        d.rdata = {16'h0000, q.gDec[0]};
      else if (regAddr == `PSSQ_GACC2)
        d.rdata = {16'h0000, q.gAcc[1]};
      else if (regAddr == `PSSQ_GDEC2)
        d.rdata = {16'h0000, q.gDec[1]};
      else if (regAddr >= `PSSQ_PRESET_F && regAddr < `PSSQ_PRESET_ACC)
        d.rdata = {16'h0000, q.presetFreq[idx]};
      else if (regAddr >= `PSSQ_PRESET_ACC && regAddr < `PSSQ_PRESET_DEC)
        d.rdata = {16'h0000, q.presetAcc[idx]};
      else if (regAddr >= `PSSQ_PRESET_DEC && regAddr < `PSSQ_SEQ_F)
        d.rdata = {16'h0000, q.presetDec[idx]};
      else if (regAddr >= `PSSQ_SEQ_F && regAddr < `PSSQ_SEQ_T)
        d.rdata = {16'h0000, (idx == 3'h0) ? q.presetFreq[0] : q.seqFreq[idx]};
      else if (regAddr >= `PSSQ_SEQ_T && regAddr < `PSSQ_SEQ_DIR)
        d.rdata = {16'h0000, q.seqTime[idx]};
      else if (regAddr >= `PSSQ_SEQ_DIR && regAddr < `PSSQ_STATUS)
        d.rdata = {30'h00000000, q.seqDir[idx]};
      else if (regAddr == `PSSQ_STATUS)
        d.rdata = {24'h000000, q.paused, q.outRun, q.reverse_direction, q.seqState, q.step};
      else if (regAddr == `PSSQ_FREQ_OUT)
        d.rdata = {16'h0000, q.freqRef};
      else if (regAddr == `PSSQ_RAMP_OUT)
        d.rdata = {16'h0000, q.rampTime};
    end

    // sequencer mode decode
    modeSingle = (q.seqMode == 3'h1) || (q.seqMode == 3'h4);
    modePeriodic = (q.seqMode == 3'h2) || (q.seqMode == 3'h5);
    modeHold = (q.seqMode == 3'h3) || (q.seqMode == 3'h6);
    modeFresh = (q.seqMode >= 3'h4);
    seqEnable = (modeSingle || modePeriodic || modeHold) && runIn
                && ((termIn & q.termMask) != 5'h00);

    // used steps, zero durations skipped
    anyStep = 1'b0;
    firstStep = 3'h0;
    lastStep = 3'h0;
    nextStep = q.step;
    for (int i = 7; i >= 0; i--)
    begin
      if (q.seqTime[i] != 16'h0000)
      begin
        anyStep = 1'b1;
        firstStep = 3'(i);
        if (3'(i) > q.step)
          nextStep = 3'(i);
      end
    end
    for (int i = 0; i < 8; i++)
    begin
      if (q.seqTime[i] != 16'h0000)
        lastStep = 3'(i);
    end

    // time base of the step durations
    tick = 1'b0;
    if (q.seqState == SEQ_RUN)
    begin
      d.tickCnt = q.tickCnt + 21'h000001;
      if (q.tickCnt >= TICK_LAST)
      begin
        d.tickCnt = 21'h000000;
        tick = 1'b1;
      end
    end
    else
      d.tickCnt = 21'h000000;

    // sequencer state machine
    case (q.seqState)
      SEQ_IDLE:
      begin
        if (seqEnable && anyStep)
        begin
          d.seqState = SEQ_RUN;
          d.paused = 1'b0;
          if (modeFresh || !q.paused)
          begin
            d.step = firstStep;
            d.elapsed = 16'h0000;
          end
        end
      end
      SEQ_RUN:
      begin
        if (!seqEnable)
        begin
          d.seqState = SEQ_IDLE;
          d.paused = 1'b1;
        end
        else if (q.elapsed >= q.seqTime[q.step])
        begin
          d.elapsed = 16'h0000;
          if (q.step >= lastStep)
          begin
            if (modePeriodic)
              d.step = firstStep;
            else if (modeHold)
              d.seqState = SEQ_HOLD;
            else
              d.seqState = SEQ_DONE;
          end
          else
            d.step = nextStep;
        end
        else if (tick)
          d.elapsed = q.elapsed + 16'h0001;
      end
      SEQ_HOLD, SEQ_DONE:
      begin
        if (!seqEnable)
        begin
          d.seqState = SEQ_IDLE;
          d.paused = 1'b0;
        end
      end
      default:
        d.seqState = SEQ_IDLE;
    endcase

    // frequency target and direction
    stepFreq = (q.step == 3'h0) ? q.presetFreq[0] : q.seqFreq[q.step];
    if (q.seqState == SEQ_RUN || q.seqState == SEQ_HOLD)
    begin
      dirCode = q.seqDir[q.step];
      target = (dirCode == `PSSQ_DIR_FWD || dirCode == `PSSQ_DIR_REV) ? stepFreq : 16'h0000;
    end
    else if (q.seqState == SEQ_DONE)
    begin
      dirCode = `PSSQ_DIR_STOP;
      target = 16'h0000;
    end
    else
    begin
      dirCode = !runIn ? `PSSQ_DIR_STOP : (revIn ? `PSSQ_DIR_REV : `PSSQ_DIR_FWD);
      target = runIn ? q.presetFreq[selIn] : 16'h0000;
    end
    d.outRun = (dirCode == `PSSQ_DIR_FWD) || (dirCode == `PSSQ_DIR_REV);
    d.forward_direction = (dirCode == `PSSQ_DIR_FWD);
    d.reverse_direction = (dirCode == `PSSQ_DIR_REV);

    // ramp time scaling
    fmax = (q.vfPattern == `PSSQ_VF_PROGRAM) ? q.maxFreq
           : (q.base60 ? `PSSQ_FMAX_60 : `PSSQ_FMAX_50);
    delta = (target > q.lastTarget) ? (target - q.lastTarget)
            : (q.lastTarget - target);
    rampIdx = (target != 16'h0000) ? selIn : q.lastIdx;
    if (q.seqState != SEQ_IDLE || !q.rampIndiv)
      rampBase = (target > q.lastTarget) ? q.gAcc[q.pairSel]
                 : q.gDec[q.pairSel];
    else
      rampBase = (target > q.lastTarget) ? q.presetAcc[rampIdx]
                 : q.presetDec[rampIdx];
    if (target != q.lastTarget && !q.divStart && !divBus.busy)
    begin
      d.divStart = 1'b1;
      d.dividend = 32'(rampBase) * 32'(delta);
      d.divisor = fmax;
      d.pendFreq = target;
      d.lastTarget = target;
      if (q.seqState == SEQ_IDLE && target != 16'h0000)
        d.lastIdx = selIn;
    end
    if (divBus.done)
    begin
      d.freqRef = q.pendFreq;
      d.rampTime = (divBus.quotient[31:16] != 16'h0000) ? 16'hFFFF
                   : divBus.quotient[15:0];
      d.rampStrobe = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.maxFreq <= `PSSQ_MAXF_RST;
      q.gAcc <= {2{`PSSQ_RAMP_RST}};
      q.gDec <= {2{`PSSQ_RAMP_RST}};
      q.presetAcc <= {8{`PSSQ_RAMP_RST}};
      q.presetDec <= {8{`PSSQ_RAMP_RST}};
      q.seqState <= SEQ_IDLE;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider and outputs
  assign divBus.start = q.divStart;
  assign divBus.dividend = q.dividend;
  assign divBus.divisor = q.divisor;

  pssq_div u_div (
    .clk  (clk),
    .rstn (rstn),
    .div  (divBus)
  );

  assign regRdata = q.rdata;
  assign freqReference = q.freqRef;
  assign rampTime = q.rampTime;
  assign rampUpdate = q.rampStrobe;
  assign forwardDirection = q.forward_direction;
  assign reverseDirection = q.reverse_direction;
  assign outputRun = q.outRun;
endmodule

// >>> pssq_props.sv
// port properties of the preset speed sequencer
`timescale 1ns/100ps
module pssq_props
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic [15:0] freqReference,
  input wire logic [15:0] rampTime,
  input wire logic        rampUpdate,
  input wire logic        forwardDirection,
  input wire logic        reverseDirection,
  input wire logic        outputRun
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rdata_idle;
    !$past(regRead) |-> regRdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its slot");
  property p_dir_excl;
    !(forwardDirection && reverseDirection);
  endproperty
  a_dir_excl: assert property (p_dir_excl)
    else $error("both directions active");
  property p_run_dir;
    outputRun == (forwardDirection || reverseDirection);
  endproperty
  a_run_dir: assert property (p_run_dir)
    else $error("run flag disagrees with direction");
  property p_upd_gap;
    rampUpdate |=> !rampUpdate [*8];
  endproperty
  a_upd_gap: assert property (p_upd_gap)
    else $error("update pulses too close");
  property p_freq_hold;
    !rampUpdate |-> $stable(freqReference);
  endproperty
  a_freq_hold: assert property (p_freq_hold)
    else $error("frequency moved without update");
  property p_ramp_hold;
    $stable(rampTime) or rampUpdate;
  endproperty
  a_ramp_hold: assert property (p_ramp_hold)
    else $error("ramp time moved without update");
  property p_freq_limit;
    freqReference <= 16'hFDE8;
  endproperty
  a_freq_limit: assert property (p_freq_limit)
    else $error("frequency above limit");
  property p_stop_freq;
    rampUpdate && !outputRun |-> freqReference == 16'h0000;
  endproperty
  a_stop_freq: assert property (p_stop_freq)
    else $error("output stopped at nonzero frequency");
  c_reverse: cover property (rampUpdate && reverseDirection);
  c_stop: cover property ($fell(outputRun));
  c_read: cover property ($past(regRead) && regRdata != 32'h00000000);
endmodule
bind pssq_top pssq_props u_pssq_props (.clk(clk), .rstn(rstn), .regRead(regRead),
  .regRdata(regRdata), .freqReference(freqReference), .rampTime(rampTime),
  .rampUpdate(rampUpdate), .forwardDirection(forwardDirection),
  .reverseDirection(reverseDirection), .outputRun(outputRun));

// >>> pssq_operator.sv
// operator switches and terminal pins of the sequencer
`timescale 1ns/100ps
module pssq_operator
(
  input  wire logic  clk,
  output logic       runCommand,
  output logic       reverseCommand,
  output logic [5:1] terminal,
  output logic [2:0] presetSelect
);
  initial
  begin
    runCommand = 1'b0;
    reverseCommand = 1'b0;
    terminal = 5'h00;
    presetSelect = 3'h0;
  end
  // levels change just after an edge and stay
  task automatic setPins(input logic run, input logic [5:1] term, input logic [2:0] sel);
    @(posedge clk);
    runCommand <= run;
    terminal <= term;
    presetSelect <= sel;
  endtask
  // direction switch, same timing as the other pins
  task automatic setReverse(input logic reverse_direction);
    @(posedge clk);
    reverseCommand <= reverse_direction;
  endtask
endmodule

// >>> test_preset_speed_auto_sequencer.sv
// self-checking bench of the preset speed sequencer
`timescale 1ns/100ps
`include "pssq_regs.svh"
module test_preset_speed_auto_sequencer;
  import pssq_pkg::*;
  logic        clk;
  logic        rstn;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        runCommand;
  logic        reverseCommand;
  logic [5:1]  terminal;
  logic [2:0]  presetSelect;
  logic [15:0] freqReference;
  logic [15:0] rampTime;
  logic        rampUpdate;
  logic        forwardDirection;
  logic        reverseDirection;
  logic        outputRun;
  int          n_mismatch;
  int          comparisons;
  int          singles[4] = '{1, 3, 4, 6};
  int          periodic[2] = '{2, 5};

  pssq_top #(.TICK_CYCLES(4)) u_pssq_top (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .runCommand(runCommand), .reverseCommand(reverseCommand),
    .multifunctionInput1(terminal[1]), .multifunctionInput2(terminal[2]),
    .multifunctionInput3(terminal[3]), .multifunctionInput4(terminal[4]),
    .multifunctionInput5(terminal[5]), .presetSelect(presetSelect),
    .freqReference(freqReference), .rampTime(rampTime), .rampUpdate(rampUpdate),
    .forwardDirection(forwardDirection), .reverseDirection(reverseDirection),
    .outputRun(outputRun));
  pssq_operator u_pssq_operator (.clk(clk), .runCommand(runCommand),
    .reverseCommand(reverseCommand), .terminal(terminal), .presetSelect(presetSelect));

  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk("register read", exp, regRdata);
  endtask

  task automatic waitUpd(input logic [15:0] f, input logic [15:0] r);
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(negedge clk);
      if (rampUpdate === 1'b1)
        break;
    end
    if (i == 400)
    begin
      n_mismatch++;
      $display("unexpected update timeout expected %h seen %h", f, freqReference);
      conclude();
    end
    else
    begin
      chk("frequency", {16'h0000, f}, {16'h0000, freqReference});
      chk("ramp time", {16'h0000, r}, {16'h0000, rampTime});
    end
  endtask

  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge clk);
      chk("update pulse", 32'h00000000, {31'h0, rampUpdate});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    regWrite = 1'b0;
    regRead = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // reset values, limits and refusals
    rd(`PSSQ_MAXF, 32'h00001770);
    rd(`PSSQ_PRESET_ACC + 8'h1C, 32'h00000064);
    wr(`PSSQ_PRESET_F + 8'h04, 32'h0000FDE9);
    rd(`PSSQ_PRESET_F + 8'h04, 32'h00000000);
    wr(`PSSQ_PRESET_F + 8'h1C, 32'h0000FDE8);
    rd(`PSSQ_PRESET_F + 8'h1C, 32'h0000FDE8);
    wr(`PSSQ_PRESET_ACC + 8'h04, 32'h00000000);
    rd(`PSSQ_PRESET_ACC + 8'h04, 32'h00000064);
    wr(`PSSQ_SEQ_T + 8'h04, 32'h00008CA1);
    rd(`PSSQ_SEQ_T + 8'h04, 32'h00000000);
    wr(`PSSQ_SEQ_F + 8'h1C, 32'h0000FDE8);
    rd(`PSSQ_SEQ_F + 8'h1C, 32'h0000FDE8);
    wr(`PSSQ_PRESET_F, 32'h000005DC);
    wr(`PSSQ_SEQ_F, 32'h00000BB8);
    rd(`PSSQ_SEQ_F, 32'h000005DC);
    rd(8'hF0, 32'h00000000);
    // individual ramps, programmable maximum
    wr(`PSSQ_CTRL, 32'h0000001D);
    wr(`PSSQ_MAXF, 32'h00001388);
    wr(`PSSQ_PRESET_F + 8'h04, 32'h000003E8);
    wr(`PSSQ_PRESET_ACC + 8'h04, 32'h00000032);
    wr(`PSSQ_PRESET_DEC + 8'h04, 32'h000000C8);
    wr(`PSSQ_PRESET_F + 8'h08, 32'h00000BB8);
    u_pssq_operator.setPins(1'b1, 5'h00, 3'h1);
    waitUpd(16'h03E8, 16'h000A);
    u_pssq_operator.setPins(1'b0, 5'h00, 3'h1);
    waitUpd(16'h0000, 16'h0028);
    u_pssq_operator.setPins(1'b1, 5'h00, 3'h1);
    waitUpd(16'h03E8, 16'h000A);
    u_pssq_operator.setPins(1'b1, 5'h00, 3'h2);
    waitUpd(16'h0BB8, 16'h0028);
    // shared ramps, second pair, then fixed 60 Hz maximum
    wr(`PSSQ_CTRL, 32'h0000001E);
    wr(`PSSQ_GDEC2, 32'h000000FA);
    u_pssq_operator.setPins(1'b1, 5'h00, 3'h1);
    waitUpd(16'h03E8, 16'h0064);
    wr(`PSSQ_CTRL, 32'h00000020);
    u_pssq_operator.setPins(1'b1, 5'h00, 3'h2);
    waitUpd(16'h0BB8, 16'h0021);
    u_pssq_operator.setPins(1'b1, 5'h00, 3'h3);
    waitUpd(16'h0000, 16'h0032);
    u_pssq_operator.setReverse(1'b1);
    quiet(5);
    chk("reverse", 32'h00000001, {31'h0, reverseDirection});
    chk("forward", 32'h00000000, {31'h0, forwardDirection});
    u_pssq_operator.setReverse(1'b0);
    // sequencer: two steps, rest unused
    wr(`PSSQ_SEQ_F + 8'h04, 32'h00000BB8);
    wr(`PSSQ_SEQ_T, 32'h00000014);
    wr(`PSSQ_SEQ_T + 8'h04, 32'h0000001E);
    wr(`PSSQ_SEQ_DIR, 32'h00000001);
    wr(`PSSQ_SEQ_DIR + 8'h04, 32'h00000002);
    wr(`PSSQ_CTRL, 32'h00000800);
    u_pssq_operator.setPins(1'b1, 5'h04, 3'h3);
    quiet(100);
    u_pssq_operator.setPins(1'b1, 5'h01, 3'h3);
    wr(`PSSQ_CTRL, 32'h00000840);
    quiet(100);
    foreach (singles[k])
    begin
      wr(`PSSQ_CTRL, 32'h00000800 | (singles[k] << 6));
      u_pssq_operator.setPins(1'b1, 5'h04, 3'h3);
      waitUpd(16'h05DC, 16'h001E);
      chk("forward", 32'h00000001, {31'h0, forwardDirection});
      waitUpd(16'h0BB8, 16'h001E);
      chk("reverse", 32'h00000001, {31'h0, reverseDirection});
      if (singles[k] % 3 == 0)
      begin
        quiet(200);
        chk("run", 32'h00000001, {31'h0, outputRun});
        u_pssq_operator.setPins(1'b1, 5'h00, 3'h3);
        waitUpd(16'h0000, 16'h003C);
      end
      else
      begin
        waitUpd(16'h0000, 16'h003C);
        chk("run", 32'h00000000, {31'h0, outputRun});
        u_pssq_operator.setPins(1'b1, 5'h00, 3'h3);
        quiet(8);
      end
    end
    foreach (periodic[k])
    begin
      wr(`PSSQ_CTRL, 32'h00000800 | (periodic[k] << 6));
      u_pssq_operator.setPins(1'b1, 5'h04, 3'h3);
      waitUpd(16'h05DC, 16'h001E);
      waitUpd(16'h0BB8, 16'h001E);
      waitUpd(16'h05DC, 16'h001E);
      waitUpd(16'h0BB8, 16'h001E);
      u_pssq_operator.setPins(1'b1, 5'h00, 3'h3);
      waitUpd(16'h0000, 16'h003C);
      u_pssq_operator.setPins(1'b1, 5'h04, 3'h3);
      if (periodic[k] == 2)
        waitUpd(16'h0BB8, 16'h003C);
      else
        waitUpd(16'h05DC, 16'h001E);
      u_pssq_operator.setPins(1'b1, 5'h00, 3'h3);
      waitUpd(16'h0000, (periodic[k] == 2) ? 16'h003C : 16'h001E);
    end
    conclude();
  end
endmodule
